// *** verilog/dtr_pkg.sv ***
// Purpose: Shared constants and types for the DRAM command timing block
// Assumes: 100 MHz system clock, four banks
// Notes: Times are in picoseconds, counts in clock cycles

package dtr_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 10000;
  localparam int ROW_ACTIVE_MIN_TIME_PS = 40000;
  localparam int BANK_PRECHARGE_PERIOD_PS = 15000;
  localparam int ROW_ACTIVE_MIN_CYC =
    (ROW_ACTIVE_MIN_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BANK_PRECHARGE_CYC =
    (BANK_PRECHARGE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Two and a half clocks; the whole part is counted here
  localparam int TERMINATION_OFF_WHOLE_CYC = 2;
  localparam int CKE_REG_EDGES = 3;
  localparam int BANK_COUNT = 4;
  localparam int CNT_W = 8;

  // ****************************************************************
  // Command encodings
  // ****************************************************************
  typedef enum logic [2:0] {
    DTR_CMD_NOP,
    DTR_CMD_ACT,
    DTR_CMD_RD_AP,
    DTR_CMD_WR_AP,
    DTR_CMD_PRE,
    DTR_CMD_PRE_ALL,
    DTR_CMD_REF
  } dtr_cmd_type;

  typedef struct packed {
    logic valid;
    dtr_cmd_type cmd;
    logic [1:0] bank;
  } dtr_req_type;

  typedef struct packed {
    logic [3:0] bank_open;
    logic [3:0] precharge_fire;
    logic termination_on;
    logic cke_active;
  } dtr_stat_type;

endpackage : dtr_pkg

// *** verilog/dtr_core.sv ***
// Purpose: Device-side command timing: auto-precharge lock-out,
//   on-die termination turn-off delay, clock-enable registration
// Assumes: Inputs synchronous to clk_sys_i; controller obeys its timing
// Notes: One design file holds all the logic

`timescale 1ns/1ns

module dtr_core #(
  parameter int BANKS = dtr_pkg::BANK_COUNT,
  parameter int ROW_MIN = dtr_pkg::ROW_ACTIVE_MIN_CYC,
  parameter int WR_RECOVERY = 4
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Command and pins
  input dtr_pkg::dtr_req_type req_i,
  input wire logic termination_ctl_i,
  input wire logic cke_i,
  // Status
  output dtr_pkg::dtr_stat_type stat_o
);
  import dtr_pkg::*;

  // ****************************************************************
  // Per-bank lock-out
  // ****************************************************************
  logic [CNT_W-1:0] row_age [BANKS];
  logic [CNT_W-1:0] next_row_age [BANKS];
  logic [CNT_W-1:0] ap_wait [BANKS];
  logic [CNT_W-1:0] next_ap_wait [BANKS];
  logic [BANKS-1:0] ap_pend, next_ap_pend;
  logic [BANKS-1:0] open_q, next_open_q;
  logic [BANKS-1:0] fire, next_fire;

  always_comb begin
    for (int b = 0; b < BANKS; b++) begin
      next_row_age[b] = row_age[b];
      next_ap_wait[b] = ap_wait[b];
      next_ap_pend[b] = ap_pend[b];
      next_open_q[b] = open_q[b];
      next_fire[b] = 1'b0;
      if (open_q[b] && row_age[b] != 8'hff) begin
        next_row_age[b] = row_age[b] + 8'h01;
      end
      if (ap_wait[b] != 8'h00) begin
        next_ap_wait[b] = ap_wait[b] - 8'h01;
      end
      // Precharge held until both row minimum and recovery are met
      if (ap_pend[b] && ap_wait[b] == 8'h00 &&
          row_age[b] >= CNT_W'(ROW_MIN)) begin
        next_ap_pend[b] = 1'b0;
        next_open_q[b] = 1'b0;
        next_fire[b] = 1'b1;
      end
      if (req_i.valid && req_i.bank == 2'(b)) begin
        case (req_i.cmd)
          DTR_CMD_ACT: begin
            next_open_q[b] = 1'b1;
            next_row_age[b] = 8'h01;
          end
          DTR_CMD_RD_AP: begin
            next_ap_pend[b] = 1'b1;
            next_ap_wait[b] = 8'h00;
          end
          DTR_CMD_WR_AP: begin
            next_ap_pend[b] = 1'b1;
            next_ap_wait[b] = CNT_W'(WR_RECOVERY);
          end
          DTR_CMD_PRE: begin
            next_open_q[b] = 1'b0;
          end
          // Refresh needs no bank state, so bursts pass freely
          default: begin
          end
        endcase
      end
      if (req_i.valid && req_i.cmd == DTR_CMD_PRE_ALL) begin
        next_open_q[b] = 1'b0;
        next_ap_pend[b] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ap_pend <= '0;
      open_q <= '0;
      fire <= '0;
      for (int b = 0; b < BANKS; b++) begin
        row_age[b] <= '0;
        ap_wait[b] <= '0;
      end
    end else begin
      ap_pend <= next_ap_pend;
      open_q <= next_open_q;
      fire <= next_fire;
      for (int b = 0; b < BANKS; b++) begin
        row_age[b] <= next_row_age[b];
        ap_wait[b] <= next_ap_wait[b];
      end
    end
  end

  // ****************************************************************
  // Termination turn-off delay
  // ****************************************************************
  logic [TERMINATION_OFF_WHOLE_CYC-1:0] odt_pipe, next_odt_pipe;
  logic term_on, next_term_on;

  always_comb begin
    next_odt_pipe = {odt_pipe[TERMINATION_OFF_WHOLE_CYC-2:0],
                     termination_ctl_i};
    // On follows input; off only after the delay line drains
    next_term_on = termination_ctl_i |
                   (|odt_pipe);
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      odt_pipe <= '0;
      term_on <= 1'b0;
    end else begin
      odt_pipe <= next_odt_pipe;
      term_on <= next_term_on;
    end
  end

  // ****************************************************************
  // Clock-enable registration
  // ****************************************************************
  logic [1:0] cke_cnt, next_cke_cnt;
  logic cke_last, next_cke_last;
  logic cke_act, next_cke_act;

  always_comb begin
    next_cke_last = cke_i;
    next_cke_cnt = cke_cnt;
    next_cke_act = cke_act;
    if (cke_i != cke_last) begin
      next_cke_cnt = 2'h1;
    end else if (cke_cnt != 2'(CKE_REG_EDGES)) begin
      next_cke_cnt = cke_cnt + 2'h1;
    end
    // New level accepted once seen on three edges in a row
    if (cke_i == cke_last && cke_cnt == 2'(CKE_REG_EDGES - 1)) begin
      next_cke_act = cke_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cke_cnt <= '0;
      cke_last <= 1'b0;
      cke_act <= 1'b0;
    end else begin
      cke_cnt <= next_cke_cnt;
      cke_last <= next_cke_last;
      cke_act <= next_cke_act;
    end
  end

  // ****************************************************************
  // Strobe grouping
  // ****************************************************************
  // Data bits served by one strobe: four or eight in narrow parts, and
  // a lower and an upper byte strobe in the sixteen-bit part
  localparam int DQ_BITS = 16;
  localparam int STROBE_GROUP_W = (DQ_BITS > 8) ? 8 : DQ_BITS;
  localparam int STROBE_COUNT = DQ_BITS / STROBE_GROUP_W;

  assign stat_o = '{bank_open: open_q, precharge_fire: fire,
                    termination_on: term_on, cke_active: cke_act};

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Lock-out is watched on the first and the last bank
  a_ap_lockout_hold: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) fire[0] |-> $past(row_age[0]) >= CNT_W'(ROW_MIN))
    else $error("precharge fired before row minimum");

  a_ap_lockout_last: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) fire[BANKS-1] |->
      $past(row_age[BANKS-1]) >= CNT_W'(ROW_MIN))
    else $error("last bank precharge fired before row minimum");

  a_fire_closes_bank: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) fire[0] |-> !open_q[0])
    else $error("bank left open after internal precharge");

  a_term_off_delay: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) $fell(termination_ctl_i) ##1
      (!termination_ctl_i) [*2] |-> term_on ##1 !term_on)
    else $error("termination off delay wrong");

  a_term_on_follow: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) termination_ctl_i |=> term_on)
    else $error("termination not on after control high");

  a_cke_three_edges: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) $rose(cke_act) |-> $past(cke_i, 1) &&
      $past(cke_i, 2) && $past(cke_i, 3))
    else $error("cke accepted early");

  a_cke_change_hold: assert property (@(posedge clk_sys_i)
    disable iff (srst_i) cke_i != $past(cke_i) |=> cke_act == $past(cke_act))
    else $error("cke accepted on a changing edge");

endmodule : dtr_core

// *** verification/dtr_host.sv ***
// Purpose: Host controller model that sends one command per go_i pulse
// Assumes: Bench spaces go_i pulses
// Notes: Early auto precharge and refresh bursts pass unchecked
`timescale 1ns/1ns
module dtr_host (
  // Clock
  input wire logic clk_sys_i,
  // From bench
  input wire logic go_i,
  input dtr_pkg::dtr_cmd_type cmd_i,
  input wire logic [1:0] bank_i,
  // To device
  output dtr_pkg::dtr_req_type req_o
);
  import dtr_pkg::*;
  always_ff @(posedge clk_sys_i) begin
    req_o <= '{valid: go_i, cmd: go_i ? cmd_i : DTR_CMD_NOP, bank: bank_i};
  end
endmodule : dtr_host

// *** verification/dtr_core_bench.sv ***
// Purpose: Self-checking bench for dtr_core
// Assumes: Host model sends commands; bench drives pins
// Notes: Integer model tracks row age and pin run lengths
`timescale 1ns/1ns
module dtr_core_bench;
  import dtr_pkg::*;
  logic clk_sys_i, srst_i, go, term, cke, ckp, rnd;
  logic [1:0] bank, b;
  dtr_cmd_type cmd;
  dtr_req_type req;
  dtr_stat_type stat;
  int err_count, n_compared, cyc, tl, th, hb, ck, d;
  int seed = 32'hbdbc;
  int act_c[4];
  bit pend[4];
  dtr_host host (.clk_sys_i, .go_i(go), .cmd_i(cmd), .bank_i(bank),
    .req_o(req));
  dtr_core dut (.clk_sys_i, .srst_i, .req_i(req), .termination_ctl_i(term),
    .cke_i(cke), .stat_o(stat));
  initial begin
    clk_sys_i = 0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string n, input logic [3:0] e, logic [3:0] g);
    n_compared++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  // One command; returns at the negedge after the device took it
  task automatic issue(input dtr_cmd_type c, input logic [1:0] k);
    @(posedge clk_sys_i);
    go <= 1'b1;
    cmd <= c;
    bank <= k;
    @(posedge clk_sys_i);
    go <= 1'b0;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask : issue
  always @(posedge clk_sys_i) begin
    cyc++;
    if (term) begin
      th++;
      tl = 0;
    end else begin
      if (tl == 0) hb = th;
      th = 0;
      tl++;
    end
    ck = (cke === ckp) ? ck + 1 : 1;
    ckp = cke;
    if (req.valid === 1'b1 && !srst_i) begin
      if (req.cmd == DTR_CMD_ACT) act_c[req.bank] = cyc;
      if (req.cmd inside {DTR_CMD_RD_AP, DTR_CMD_WR_AP}) pend[req.bank] = 1;
      if (req.cmd == DTR_CMD_PRE) pend[req.bank] = 0;
      if (req.cmd == DTR_CMD_PRE_ALL) pend = '{0, 0, 0, 0};
    end
    if (rnd && $random(seed) % 4 == 0) term <= ~term;
    if (rnd && ck >= 3 && $random(seed) % 5 == 0) cke <= ~cke;
  end
  always @(negedge clk_sys_i) if (!srst_i) begin
    for (int i = 0; i < 4; i++) begin
      d = cyc - act_c[i];
      if (stat.precharge_fire[i] === 1'b1) begin
        chk("fire pending", 4'h1, pend[i]);
        chk("fire age", 4'h1, d >= ROW_ACTIVE_MIN_CYC);
        pend[i] = 0;
      end else if (pend[i] && d > ROW_ACTIVE_MIN_CYC + 9) begin
        chk("fire late", 4'h1, 4'h0);
      end
      if (pend[i] && d < ROW_ACTIVE_MIN_CYC) begin
        chk("open", 4'h1, stat.bank_open[i]);
      end
    end
    if (th > 0) chk("term on", 4'h1, stat.termination_on);
    if (tl >= 3) chk("term off", 4'h0, stat.termination_on);
    if (tl > 0 && tl < 3 && hb > 0) begin
      chk("term hold", 4'h1, stat.termination_on);
    end
    if (ck >= 3) chk("cke level", ckp, stat.cke_active);
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_count++;
    tally_and_finish;
  end
  initial begin
    srst_i = 1;
    go = 0;
    term = 0;
    cke = 0;
    rnd = 0;
    cmd = DTR_CMD_NOP;
    bank = 0;
    repeat (20) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(negedge clk_sys_i);
    chk("reset open", 4'h0, stat.bank_open);
    repeat (8) @(negedge clk_sys_i);
    rnd = 1;
    for (int i = 0; i < 12; i++) begin
      b = (i < 4) ? 2'(i) : 2'($random(seed));
      issue(DTR_CMD_ACT, b);
      chk("open after act", 4'h1, stat.bank_open[b]);
      issue(i[0] ? DTR_CMD_WR_AP : DTR_CMD_RD_AP, b);
      repeat (16) @(posedge clk_sys_i);
    end
    issue(DTR_CMD_ACT, 2'h1);
    issue(DTR_CMD_PRE, 2'h1);
    chk("open after pre", 4'h0, stat.bank_open[1]);
    issue(DTR_CMD_ACT, 2'h2);
    issue(DTR_CMD_RD_AP, 2'h2);
    issue(DTR_CMD_PRE_ALL, 2'h0);
    chk("open after all", 4'h0, stat.bank_open);
    issue(DTR_CMD_REF, 2'h0);
    issue(DTR_CMD_REF, 2'h0);
    issue(DTR_CMD_NOP, 2'h0);
    // Mid-run reset with clock enable registered low first
    rnd = 0;
    repeat (3) @(posedge clk_sys_i);
    cke <= 1'b0;
    term <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    srst_i <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(negedge clk_sys_i);
    chk("reset2 open", 4'h0, stat.bank_open);
    chk("reset2 cke", 4'h0, stat.cke_active);
    chk("reset2 term", 4'h0, stat.termination_on);
    issue(DTR_CMD_ACT, 2'h3);
    issue(DTR_CMD_RD_AP, 2'h3);
    repeat (20) @(posedge clk_sys_i);
    tally_and_finish;
  end
endmodule : dtr_core_bench
